/* verilog/usd_map.vh */
// Purpose: Constants for the serial port status and baud divisor block
// Assumes: Byte-wide I/O bus with three address bits
// Notes:   Offsets are address codes, not byte addresses
//
// Overview of operation
// - Line status is read-only; flags in bits one to four raise a line interrupt
// - Receive-ready bit sets on a character arriving, clears on receive buffer read
// - Overrun bit sets when an unread character is replaced; line status read clears
// - Parity mismatch bit sets on wrong parity; line status read clears it
// - Framing bit sets when the stop bit is missing; line status read clears it
// - Break bit sets when input stays low a whole character; read clears it
// - Holding-empty bit sets on transfer to shifter, interrupts if enabled, write clears
// - Transmitter-idle bit is one only while holding buffer and shifter are empty
// - Modem change bits set on input change, clear on read, interrupt if enabled
// - Change bits zero to three track CTS, DSR, bell line and carrier inputs
// - Modem bit four is inverted CTS, or the RTS control bit in loopback
// - Modem bit five is inverted bell line input, or DTR control bit in loopback
// - Modem bit six is inverted DSR input, or control bit two in loopback
// - Modem bit seven is inverted carrier input, or control bit three in loopback
// - Sixteen-bit divisor in two byte registers divides the 1.8432 MHz reference
// - Control bit four selects loopback; control bits five to seven read zero
// - Format bit seven steers the two lowest selects onto the divisor bytes
// - Interrupt priority: line, receive, transmit, modem; identity shows the highest
`ifndef USD_MAP_VH
`define USD_MAP_VH

// Address codes
`define USD_OFF_DATA     3'h0
`define USD_OFF_MASK     3'h1
`define USD_OFF_IDENT    3'h2
`define USD_OFF_FORMAT   3'h3
`define USD_OFF_CONTROL  3'h4
`define USD_OFF_LINE     3'h5
`define USD_OFF_MODEM    3'h6
`define USD_OFF_SCRATCH  3'h7

// Format register fields
`define USD_FMT_STOP     2
`define USD_FMT_PAR_EN   3
`define USD_FMT_EVEN     4
`define USD_FMT_FORCE    5
`define USD_FMT_BREAK    6
`define USD_FMT_DIVSEL   7

// Control register fields
`define USD_CTL_DTR      0
`define USD_CTL_RTS      1
`define USD_CTL_LOOP     4

// Reset values
`define USD_RST_DIVISOR  16'h000C
`define USD_RST_BYTE     8'h00

// Timing counts in sampling ticks
`define USD_TICKS_BIT    9'd16
`define USD_TICKS_HALF   4'd7
`define USD_TICKS_STOP1  9'd16
`define USD_TICKS_STOP15 9'd24
`define USD_TICKS_STOP2  9'd32

`endif

/* verilog/usd_uart.v */
// Purpose: Serial port line and modem status, baud divisor, receiver and transmitter
// Assumes: Reference clock arrives as a slow pin and is sampled on clk
// Notes:   Register reads return data one clock after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "usd_map.vh"

module usd_uart (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // I/O bus
  input  wire       cs,
  input  wire [2:0] addr,
  input  wire       rd_stb,
  input  wire       wr_stb,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata_ff,
  // Reference clock pin
  input  wire       ref_clk,
  // Serial data
  input  wire       rxd,
  output reg        txd_ff,
  // Modem lines, active low
  input  wire       cts_n,
  input  wire       dsr_n,
  input  wire       bell_line_n,
  input  wire       carrier_n,
  output reg        rts_n_ff,
  output reg        dtr_n_ff,
  // Interrupt request
  output reg        intr_ff
);

  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS  = 2'd2;
  localparam RX_STOP  = 2'd3;
  localparam [15:0] RST_DIV = `USD_RST_DIVISOR;

  // Register select with divisor steering
  function sel;
    input [2:0] a;
    input       dsel;
    input [2:0] off;
    input       need_dsel;
    begin
      sel = (a == off) && (need_dsel ? dsel : !(dsel && off[2:1] == 2'b00));
    end
  endfunction

  // Pin synchronisers
  wire [5:0] pins_in = {carrier_n, bell_line_n, dsr_n, cts_n, ref_clk, rxd};
  reg  [5:0] meta_ff;
  reg  [5:0] sync_ff;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[g] <= 1'b1;
          sync_ff[g] <= 1'b1;
        end else begin
          meta_ff[g] <= pins_in[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  // Software registers
  reg  [7:0] byte_format_ff;
  reg  [7:0] interrupt_mask_ff;
  reg  [4:0] line_control_outputs_ff;
  reg  [7:0] scratch_ff;
  reg  [7:0] baud_divisor_low_ff;
  reg  [7:0] baud_divisor_high_ff;
  wire       divisor_select_bit = byte_format_ff[`USD_FMT_DIVSEL];
  wire       loop = line_control_outputs_ff[`USD_CTL_LOOP];
  wire [1:0] wl = byte_format_ff[1:0];
  wire       par_en = byte_format_ff[`USD_FMT_PAR_EN];
  wire       par_even = byte_format_ff[`USD_FMT_EVEN];
  wire       par_force = byte_format_ff[`USD_FMT_FORCE];
  wire [3:0] nd = {2'b00, wl} + 4'd5;
  wire [7:0] dmask = 8'hFF >> (3'd3 - {1'b0, wl});

  wire rd = cs & rd_stb;
  wire wr = cs & wr_stb;
  wire rx_rd   = rd & sel(addr, divisor_select_bit, `USD_OFF_DATA, 1'b0);
  wire tx_wr   = wr & sel(addr, divisor_select_bit, `USD_OFF_DATA, 1'b0);
  wire dl_wr   = wr & sel(addr, divisor_select_bit, `USD_OFF_DATA, 1'b1);
  wire dh_wr   = wr & sel(addr, divisor_select_bit, `USD_OFF_MASK, 1'b1);
  wire msk_wr  = wr & sel(addr, divisor_select_bit, `USD_OFF_MASK, 1'b0);
  wire line_rd = rd & (addr == `USD_OFF_LINE);
  wire mdm_rd  = rd & (addr == `USD_OFF_MODEM);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_format_ff          <= `USD_RST_BYTE;
      interrupt_mask_ff       <= `USD_RST_BYTE;
      line_control_outputs_ff <= 5'h00;
      scratch_ff              <= `USD_RST_BYTE;
      baud_divisor_low_ff     <= RST_DIV[7:0];
      baud_divisor_high_ff    <= RST_DIV[15:8];
    end else begin
      if (wr && addr == `USD_OFF_FORMAT)
        byte_format_ff <= wdata;
      if (msk_wr)
        interrupt_mask_ff <= {4'h0, wdata[3:0]};
      if (wr && addr == `USD_OFF_CONTROL)
        line_control_outputs_ff <= wdata[4:0];
      if (wr && addr == `USD_OFF_SCRATCH)
        scratch_ff <= wdata;
      if (dl_wr)
        baud_divisor_low_ff <= wdata;
      if (dh_wr)
        baud_divisor_high_ff <= wdata;
    end
  end

  // Sampling tick from reference edges
  wire [15:0] divisor = {baud_divisor_high_ff, baud_divisor_low_ff};
  reg  [15:0] baud_cnt_ff;
  reg         ref_prev_ff;
  reg         tick_ff;
  wire        ref_rise = sync_ff[1] & ~ref_prev_ff;
  wire        cnt_end = (divisor == 16'h0000) || (baud_cnt_ff >= divisor - 16'h0001);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_ff <= 1'b1;
      baud_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else begin
      ref_prev_ff <= sync_ff[1];
      tick_ff     <= ref_rise & cnt_end;
      if (dl_wr || dh_wr)
        baud_cnt_ff <= 16'h0000;
      else if (ref_rise)
        baud_cnt_ff <= cnt_end ? 16'h0000 : baud_cnt_ff + 16'h0001;
    end
  end

  // Transmitter
  reg  [7:0]  thr_ff;
  reg         transmit_holding_empty_ff;
  reg  [11:0] tsr_ff;
  reg  [8:0]  tx_left_ff;
  reg  [3:0]  tx_sub_ff;
  wire        tx_busy = (tx_left_ff != 9'd0);
  wire        tx_load = ~transmit_holding_empty_ff & ~tx_busy & ~tx_wr;
  wire        tx_line = tx_busy ? tsr_ff[0] : 1'b1;
  wire        tx_wire = byte_format_ff[`USD_FMT_BREAK] ? 1'b0 : tx_line;
  wire        transmitter_idle = transmit_holding_empty_ff & ~tx_busy;
  reg  [11:0] frame;
  reg  [8:0]  frame_ticks;
  reg  [7:0]  tx_data;

  always @* begin
    tx_data = thr_ff & dmask;
    frame = (12'hFFF << (nd + 4'd1)) | {3'b000, tx_data, 1'b0};
    if (par_en)
      frame[nd + 4'd1] = par_force ? ~par_even : (^tx_data) ^ ~par_even;
    frame_ticks = `USD_TICKS_BIT * ({5'h00, nd} + 9'd1 + {8'h00, par_en});
    if (!byte_format_ff[`USD_FMT_STOP])
      frame_ticks = frame_ticks + `USD_TICKS_STOP1;
    else if (wl == 2'b00)
      frame_ticks = frame_ticks + `USD_TICKS_STOP15;
    else
      frame_ticks = frame_ticks + `USD_TICKS_STOP2;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_ff                    <= 8'h00;
      transmit_holding_empty_ff <= 1'b1;
      tsr_ff                    <= 12'hFFF;
      tx_left_ff                <= 9'd0;
      tx_sub_ff                 <= 4'd0;
    end else begin
      if (tx_wr) begin
        thr_ff                    <= wdata;
        transmit_holding_empty_ff <= 1'b0;
      end else if (tx_load) begin
        transmit_holding_empty_ff <= 1'b1;
      end
      if (tx_load) begin
        tsr_ff     <= frame;
        tx_left_ff <= frame_ticks;
        tx_sub_ff  <= 4'd0;
      end else if (tick_ff && tx_busy) begin
        tx_left_ff <= tx_left_ff - 9'd1;
        tx_sub_ff  <= tx_sub_ff + 4'd1;
        if (tx_sub_ff == 4'd15)
          tsr_ff <= {1'b1, tsr_ff[11:1]};
      end
    end
  end

  // Receiver
  reg  [1:0] rx_state_ff;
  reg  [3:0] rx_sub_ff;
  reg  [3:0] rx_idx_ff;
  reg  [8:0] rx_sh_ff;
  reg        rx_zero_ff;
  reg  [7:0] rbr_ff;
  reg        receive_data_ready_ff;
  reg        overrun_ff;
  reg        parity_mismatch_flag_ff;
  reg        framing_flag_ff;
  reg        break_seen_flag_ff;
  wire       rx_in = loop ? tx_wire : sync_ff[0];
  wire [3:0] rx_nbits = nd + {3'b000, par_en};
  wire [8:0] rx_word = rx_sh_ff >> (4'd9 - rx_nbits);
  wire [7:0] rx_data = rx_word[7:0] & dmask;
  wire       rx_pbit = rx_sh_ff[8];
  wire       rx_done = tick_ff && rx_state_ff == RX_STOP && rx_sub_ff == 4'd15;
  wire       par_bad = par_en & (par_force ? (rx_pbit != ~par_even)
                                           : (((^rx_data) ^ rx_pbit) != ~par_even));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_sub_ff   <= 4'd0;
      rx_idx_ff   <= 4'd0;
      rx_sh_ff    <= 9'h000;
      rx_zero_ff  <= 1'b0;
      rbr_ff      <= 8'h00;
    end else if (tick_ff) begin
      rx_sub_ff <= rx_sub_ff + 4'd1;
      case (rx_state_ff)
        RX_IDLE: begin
          rx_sub_ff <= 4'd0;
          if (!rx_in)
            rx_state_ff <= RX_START;
        end
        RX_START: begin
          if (rx_sub_ff == `USD_TICKS_HALF) begin
            rx_sub_ff   <= 4'd0;
            rx_idx_ff   <= 4'd0;
            rx_zero_ff  <= 1'b1;
            rx_state_ff <= rx_in ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_sub_ff == 4'd15) begin
            rx_sh_ff   <= {rx_in, rx_sh_ff[8:1]};
            rx_zero_ff <= rx_zero_ff & ~rx_in;
            rx_idx_ff  <= rx_idx_ff + 4'd1;
            if (rx_idx_ff == rx_nbits - 4'd1)
              rx_state_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sub_ff == 4'd15) begin
            rbr_ff      <= rx_data;
            rx_state_ff <= RX_IDLE;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // Line status flags, set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_data_ready_ff   <= 1'b0;
      overrun_ff              <= 1'b0;
      parity_mismatch_flag_ff <= 1'b0;
      framing_flag_ff         <= 1'b0;
      break_seen_flag_ff      <= 1'b0;
    end else begin
      receive_data_ready_ff <= rx_done | (receive_data_ready_ff & ~rx_rd);
      overrun_ff <= (rx_done & receive_data_ready_ff & ~rx_rd)
                    | (overrun_ff & ~line_rd);
      parity_mismatch_flag_ff <= (rx_done & par_bad)
                                 | (parity_mismatch_flag_ff & ~line_rd);
      framing_flag_ff <= (rx_done & ~rx_in) | (framing_flag_ff & ~line_rd);
      break_seen_flag_ff <= (rx_done & ~rx_in & rx_zero_ff)
                            | (break_seen_flag_ff & ~line_rd);
    end
  end

  wire [7:0] line_status = {1'b0, transmitter_idle, transmit_holding_empty_ff,
                            break_seen_flag_ff, framing_flag_ff, parity_mismatch_flag_ff,
                            overrun_ff, receive_data_ready_ff};

  // Modem status
  wire [3:0] modem_eff = loop ? {line_control_outputs_ff[3:2],
                                 line_control_outputs_ff[`USD_CTL_DTR],
                                 line_control_outputs_ff[`USD_CTL_RTS]}
                              : ~sync_ff[5:2];
  reg  [3:0] modem_prev_ff;
  reg  [3:0] modem_delta_ff;
  wire       cts_changed       = modem_delta_ff[0];
  wire       dsr_changed       = modem_delta_ff[1];
  wire       bell_line_changed = modem_delta_ff[2];
  wire       cts_level         = modem_eff[0];
  wire       data_set_level    = loop ? modem_eff[1] : modem_eff[2];
  wire       bell_line_level   = loop ? modem_eff[2] : modem_eff[1];
  wire       carrier_level     = modem_eff[3];
  wire [7:0] modem_status = {carrier_level, bell_line_level, data_set_level, cts_level,
                             modem_delta_ff[3], bell_line_changed, dsr_changed, cts_changed};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_prev_ff  <= 4'h0;
      modem_delta_ff <= 4'h0;
    end else begin
      modem_prev_ff  <= modem_eff;
      modem_delta_ff <= (modem_eff ^ modem_prev_ff)
                        | (modem_delta_ff & ~{4{mdm_rd}});
    end
  end

  // Interrupt priority and identity
  wire       src_line = interrupt_mask_ff[2] & (|line_status[4:1]);
  wire       src_rx   = interrupt_mask_ff[0] & receive_data_ready_ff;
  wire       src_tx   = interrupt_mask_ff[1] & transmit_holding_empty_ff;
  wire       src_mdm  = interrupt_mask_ff[3] & (|modem_delta_ff);
  wire       pending  = src_line | src_rx | src_tx | src_mdm;
  wire [1:0] src_code = src_line ? 2'b11 : src_rx ? 2'b10 :
                        src_tx ? 2'b01 : 2'b00;
  // Receive reads as bit 2 set, transmit as bit 1 set
  wire [7:0] ident = {5'h00, src_code[1], src_code[0], ~pending};

  // Read data and pins
  reg  [7:0] rd_mux;
  always @* begin
    case (addr)
      `USD_OFF_DATA:    rd_mux = divisor_select_bit ? baud_divisor_low_ff : rbr_ff;
      `USD_OFF_MASK:    rd_mux = divisor_select_bit ? baud_divisor_high_ff : interrupt_mask_ff;
      `USD_OFF_IDENT:   rd_mux = ident;
      `USD_OFF_FORMAT:  rd_mux = byte_format_ff;
      `USD_OFF_CONTROL: rd_mux = {3'b000, line_control_outputs_ff};
      `USD_OFF_LINE:    rd_mux = line_status;
      `USD_OFF_MODEM:   rd_mux = modem_status;
      default:          rd_mux = scratch_ff;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      txd_ff   <= 1'b1;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      intr_ff  <= 1'b0;
    end else begin
      if (rd)
        rdata_ff <= rd_mux;
      txd_ff   <= loop ? 1'b1 : tx_wire;
      rts_n_ff <= loop | ~line_control_outputs_ff[`USD_CTL_RTS];
      dtr_n_ff <= loop | ~line_control_outputs_ff[`USD_CTL_DTR];
      intr_ff  <= pending;
    end
  end

endmodule
`default_nettype wire

/* testbench/usd_uart_chk.sv */
// Purpose: Port-level checker for the serial status and divisor block
// Assumes: Address codes 0..7, format bit 7 steers codes 0 and 1 onto the divisor
// Notes:   Shadows what the bus wrote and the modem pins; age counts settle time after changes
`timescale 1ns/1ps
`default_nettype none
module usd_uart_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // I/O bus
  input wire logic       cs,
  input wire logic [2:0] addr,
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata_ff,
  // Pins
  input wire logic       txd_ff,
  input wire logic       cts_n,
  input wire logic       dsr_n,
  input wire logic       bell_line_n,
  input wire logic       carrier_n,
  input wire logic       rts_n_ff,
  input wire logic       dtr_n_ff,
  input wire logic       intr_ff
);
  logic [7:0] ctl_ff;
  logic       dsel_ff;
  logic [7:0] dlo_ff;
  logic [3:0] mask_ff;
  logic [3:0] pins_ff;
  logic [2:0] age_ff;
  wire        wr_hit = cs && wr_stb;
  wire        rd_hit = cs && rd_stb;
  wire  [3:0] pins   = {carrier_n, bell_line_n, dsr_n, cts_n};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff  <= 8'h00;
      dsel_ff <= 1'b0;
      dlo_ff  <= 8'h0c;
      mask_ff <= 4'h0;
      pins_ff <= 4'hf;
      age_ff  <= 3'h0;
    end else begin
      if (wr_hit && addr == 3'h4) ctl_ff <= wdata;
      if (wr_hit && addr == 3'h3) dsel_ff <= wdata[7];
      if (wr_hit && addr == 3'h0 && dsel_ff) dlo_ff <= wdata;
      if (wr_hit && addr == 3'h1 && !dsel_ff) mask_ff <= wdata[3:0];
      pins_ff <= pins;
      // Settle time since the last control write or pin change
      age_ff  <= ((wr_hit && addr == 3'h4) || pins != pins_ff) ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  line_top_a: assert property (rd_hit && addr == 3'h5 |=> rdata_ff[7] == 1'b0)
    else $error("line status bit 7 set");
  ctl_zero_a: assert property (rd_hit && addr == 3'h4 |=> rdata_ff[7:5] == 3'h0)
    else $error("control bits 7:5 not zero");
  ident_zero_a: assert property (rd_hit && addr == 3'h2 |=> rdata_ff[7:3] == 5'h00)
    else $error("identity bits 7:3 not zero");
  txw_flags_a: assert property (wr_hit && addr == 3'h0 && !dsel_ff ##2 rd_hit && addr == 3'h5
    |=> !rdata_ff[6]) else $error("transmitter idle right after a write");
  idle_empty_a: assert property (rd_hit && addr == 3'h5 |=> !rdata_ff[6] || rdata_ff[5])
    else $error("idle without empty holding buffer");
  loop_pins_a: assert property (ctl_ff[4] && age_ff >= 3'h3 |-> rts_n_ff && dtr_n_ff && txd_ff)
    else $error("pins active in loopback");
  ctl_pins_a: assert property (!ctl_ff[4] && age_ff >= 3'h3
    |-> rts_n_ff == !ctl_ff[1] && dtr_n_ff == !ctl_ff[0]) else $error("control pins wrong");
  loop_modem_a: assert property (rd_hit && addr == 3'h6 && ctl_ff[4] && age_ff >= 3'h4
    |=> rdata_ff[7:4] == {ctl_ff[3], ctl_ff[2], ctl_ff[0], ctl_ff[1]}) else $error("loopback levels wrong");
  modem_lvl_a: assert property (rd_hit && addr == 3'h6 && !ctl_ff[4] && age_ff >= 3'h4
    |=> rdata_ff[7:4] == ~{pins_ff[3], pins_ff[1], pins_ff[2], pins_ff[0]}) else $error("modem levels wrong");
  div_read_a: assert property (rd_hit && addr == 3'h0 && dsel_ff |=> rdata_ff == $past(dlo_ff))
    else $error("divisor low byte wrong");
  intr_quiet_a: assert property (mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !intr_ff)
    else $error("request with all sources masked");

  rx_ident_c: cover property (rd_hit && addr == 3'h2 ##1 rdata_ff == 8'h04);
  brk_seen_c: cover property (rd_hit && addr == 3'h5 ##1 rdata_ff[4]);
  ovr_seen_c: cover property (rd_hit && addr == 3'h5 ##1 rdata_ff[1]);
endmodule

bind usd_uart usd_uart_chk chk_i (
  .clk(clk), .rst_n(rst_n), .cs(cs), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
  .rdata_ff(rdata_ff), .txd_ff(txd_ff), .cts_n(cts_n), .dsr_n(dsr_n), .bell_line_n(bell_line_n),
  .carrier_n(carrier_n), .rts_n_ff(rts_n_ff), .dtr_n_ff(dtr_n_ff), .intr_ff(intr_ff)
);
`default_nettype wire

/* testbench/usd_modem_model.sv */
// Purpose: Far-end data set with a free-running reference crystal
// Assumes: Serial line is looped back at the far end
// Notes:   Modem lines are active low and set by the bench
`timescale 1ns/1ps
`default_nettype none
module usd_modem_model (
  // Bench side
  input  wire logic       txd,
  input  wire logic [3:0] lines,
  // Port side
  output var  logic       ref_clk,
  output wire logic       rxd,
  output wire logic       cts_n,
  output wire logic       dsr_n,
  output wire logic       bell_line_n,
  output wire logic       carrier_n
);
  initial ref_clk = 1'b0;
  // Ten port clocks per reference period keeps frames short
  always #25 ref_clk = ~ref_clk;
  assign rxd = txd;
  assign {carrier_n, bell_line_n, dsr_n, cts_n} = lines;
endmodule
`default_nettype wire

/* testbench/usd_uart_bench.sv */
// Purpose: Self-checking bench for the serial status and divisor block
// Assumes: Far end echoes the serial line; divisor 1 gives 160 clocks a bit
// Notes:   Interrupt line is polled so status reads do not disturb flags
`timescale 1ns/1ps
`default_nettype none
module usd_uart_bench;
  logic       clk;
  logic       rst_n;
  logic       cs;
  logic       rd_stb;
  logic       wr_stb;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [3:0] lines;
  logic [7:0] got;
  wire  [7:0] rdata_ff;
  wire        ref_clk, rxd, txd_ff, rts_n_ff, dtr_n_ff, intr_ff;
  wire        cts_n, dsr_n, bell_line_n, carrier_n;
  int         bad_count;
  int         n_checks;
  int         cyc;
  logic [3:0] pat  [5] = '{4'he, 4'hc, 4'h8, 4'h0, 4'hf};
  logic [7:0] mexp [5] = '{8'h11, 8'h52, 8'h74, 8'hf8, 8'h0f};

  usd_uart uut (
    .clk(clk), .rst_n(rst_n), .cs(cs), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
    .rdata_ff(rdata_ff), .ref_clk(ref_clk), .rxd(rxd), .txd_ff(txd_ff), .cts_n(cts_n), .dsr_n(dsr_n),
    .bell_line_n(bell_line_n), .carrier_n(carrier_n), .rts_n_ff(rts_n_ff), .dtr_n_ff(dtr_n_ff), .intr_ff(intr_ff)
  );
  usd_modem_model far (
    .txd(txd_ff), .lines(lines), .ref_clk(ref_clk), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n),
    .bell_line_n(bell_line_n), .carrier_n(carrier_n)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling well above the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {cs, wr_stb, addr, wdata} <= {2'b11, a, d};
    @(posedge clk);
    {cs, wr_stb} <= 2'b00;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    {cs, rd_stb, addr} <= {2'b11, a};
    @(posedge clk);
    {cs, rd_stb} <= 2'b00;
    #1 got = rdata_ff;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask

  task automatic wait_intr;
    int n;
    n = 0;
    while (intr_ff !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, intr_ff}, 8'h01);
  endtask

  initial begin
    {rst_n, cs, rd_stb, wr_stb, addr, wdata} = '0;
    lines     = 4'hf;
    bad_count = 0;
    n_checks  = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset state and divisor bytes
    rdchk(3'h5, 8'h60);
    rdchk(3'h2, 8'h01);
    wr(3'h3, 8'h80);
    rdchk(3'h0, 8'h0c);
    rdchk(3'h1, 8'h00);
    wr(3'h0, 8'h01);
    rdchk(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    rdchk(3'h3, 8'h03);
    wr(3'h1, 8'h05);
    // One character out and back
    wr(3'h0, 8'ha5);
    rdchk(3'h5, 8'h20);
    wait_intr();
    rdchk(3'h2, 8'h04);
    repeat (200) @(posedge clk);
    rdchk(3'h5, 8'h61);
    rdchk(3'h0, 8'ha5);
    rdchk(3'h5, 8'h60);
    // Second character lands on an unread one
    wr(3'h0, 8'h3c);
    wr(3'h0, 8'h5a);
    wait_intr();
    repeat (2000) @(posedge clk);
    rdchk(3'h2, 8'h06);
    rdchk(3'h5, 8'h63);
    rdchk(3'h5, 8'h61);
    rdchk(3'h0, 8'h5a);
    // Line held at space for a whole character
    wr(3'h3, 8'h43);
    wait_intr();
    rdchk(3'h2, 8'h06);
    wr(3'h3, 8'h03);
    repeat (2000) @(posedge clk);
    rd(3'h5);
    chk(got & 8'h10, 8'h10);
    rd(3'h5);
    chk(got & 8'h1e, 8'h00);
    rd(3'h0);
    // Sent with even parity, checked as odd after the shifter loads
    wr(3'h3, 8'h1b);
    wr(3'h0, 8'h96);
    wr(3'h3, 8'h0b);
    wait_intr();
    rdchk(3'h2, 8'h06);
    repeat (200) @(posedge clk);
    rdchk(3'h5, 8'h65);
    rdchk(3'h5, 8'h61);
    rdchk(3'h0, 8'h96);
    wr(3'h1, 8'h02);
    rdchk(3'h2, 8'h02);
    wr(3'h1, 8'h05);
    wr(3'h3, 8'h03);
    // Loopback substitutes the control bits
    wr(3'h4, 8'hff);
    repeat (8) @(posedge clk);
    rdchk(3'h4, 8'h1f);
    rdchk(3'h6, 8'hff);
    rdchk(3'h6, 8'hf0);
    wr(3'h4, 8'h10);
    repeat (8) @(posedge clk);
    rdchk(3'h6, 8'h0f);
    wr(3'h4, 8'h00);
    repeat (8) @(posedge clk);
    rdchk(3'h6, 8'h00);
    // Each far-end modem line in turn
    wr(3'h1, 8'h08);
    wr(3'h4, 8'h03);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      lines <= pat[i];
      repeat (8) @(posedge clk);
      rdchk(3'h2, 8'h00);
      rdchk(3'h6, mexp[i]);
    end
    rdchk(3'h2, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
